// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk, rstn, psel, penable, pwrite, lastErr;
  logic [7:0]  paddr, rxChar, bufData;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rxValid, bdIntEnable, bufWrite, bufClose, irq;
  int          failures = 0;
  int          numChecks = 0;
  typedef logic [27:0] ucm_row_t; // mask, char, ie, write, close, reject
  ucm_row_t    rows [8] = '{28'hc0ff41c, 28'hc0ff0de, 28'hc0ff0d6, 28'hc0ff039,
                            28'hc0ff0cc, 28'hc0fe0ce, 28'hc0fe029, 28'hc0f005e};
  logic [15:0] cfg [5] = '{16'h000d, 16'h4003, 16'h400d, 16'h8000, 16'h0041};

  ucm_ctrl_char DUT (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxChar(rxChar),
    .rxValid(rxValid), .bdIntEnable(bdIntEnable), .bufData(bufData), .bufWrite(bufWrite),
    .bufClose(bufClose), .irq(irq));
  ucm_rx_source src (.sys_clk(sys_clk), .rxChar(rxChar), .rxValid(rxValid), .bdIntEnable(bdIntEnable));

  // clock generator
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until ready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: no ready", $time);
    end
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wrap_up;
    if (failures == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    #2000000;
    failures++;
    wrap_up();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    apb(1'b0, ucm_pkg::OFF_TABLE, 32'h0, rd);
    chk(rd, 32'h0000_8000);
    apb(1'b0, ucm_pkg::OFF_MASK, 32'h0, rd);
    chk(rd, 32'h0000_c0ff);
    apb(1'b1, 8'h34, 32'h0000_00ff, rd);
    apb(1'b0, 8'h34, 32'h0, rd);
    chk(rd, 32'h0);
    chk(lastErr, 1'b1);
    foreach (cfg[i]) apb(1'b1, 8'(i * 4), {16'h0, cfg[i]}, rd);
    apb(1'b1, ucm_pkg::OFF_INTMASK, 32'h3, rd);
    apb(1'b1, ucm_pkg::OFF_CTRL, 32'h1, rd);
    foreach (rows[i]) begin
      apb(1'b1, ucm_pkg::OFF_MASK, {16'h0, rows[i][27:12]}, rd);
      src.send(rows[i][11:4], rows[i][3]);
      #1;
      chk(bufWrite, rows[i][2]);
      chk(bufClose, rows[i][1]);
      if (rows[i][2]) chk(bufData, rows[i][11:4]);
      @(posedge sys_clk);
      #1;
      chk(irq, (rows[i][1] & rows[i][3]) | rows[i][0]);
      apb(1'b0, ucm_pkg::OFF_STATUS, 32'h0, rd);
      chk(rd[1:0], {rows[i][0], rows[i][1] & rows[i][3]});
      if (rows[i][0]) begin
        apb(1'b0, ucm_pkg::OFF_RECEIVED_CTRL_CHAR_REG, 32'h0, rd);
        chk(rd, rows[i][11:4]);
      end
      repeat (2) @(posedge sys_clk);
      #1;
      chk(irq, 1'b0);
    end
    // a masked reject keeps the line low until unmasked
    apb(1'b1, ucm_pkg::OFF_MASK, 32'h0000_c0ff, rd);
    apb(1'b1, ucm_pkg::OFF_INTMASK, 32'h0, rd);
    src.send(8'h03, 1'b1);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(irq, 1'b0);
    apb(1'b1, ucm_pkg::OFF_INTMASK, 32'h2, rd);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(irq, 1'b1);
    apb(1'b0, ucm_pkg::OFF_STATUS, 32'h0, rd);
    chk(rd[1:0], 2'h2);
    chk(rd[4:2], 3'h1);
    // mid-run reset: pending interrupt drops, table and enable return to idle
    src.send(8'h03, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(irq, 1'b1);
    @(posedge sys_clk);
    rstn <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(irq, 1'b0);
    chk(bufWrite, 1'b0);
    @(posedge sys_clk);
    rstn <= 1'b1;
    apb(1'b0, ucm_pkg::OFF_TABLE, 32'h0, rd);
    chk(rd, 32'h0000_8000);
    apb(1'b0, ucm_pkg::OFF_CTRL, 32'h0, rd);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire

// *** sim/ucm_ctrl_char_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module ucm_ctrl_char_asserts (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [7:0] rxChar,
  input wire logic       rxValid,
  input wire logic [7:0] bufData,
  input wire logic       bufWrite,
  input wire logic       bufClose,
  input wire logic       irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // stream side: writes and closes follow the taken character
  property p_wr_cause; bufWrite |-> $past(rxValid); endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("buffer write without character");
  property p_wr_data; bufWrite |-> bufData == $past(rxChar); endproperty
  a_wr_data: assert property (p_wr_data) else $error("buffer data differs from character");
  property p_close; bufClose |-> bufWrite; endproperty
  a_close: assert property (p_close) else $error("close without stored character");
  // interrupt level moves only after an event or a register access
  property p_irq_up; $rose(irq) |-> $past(rxValid, 2) || $past(pready) || $past(pready, 2); endproperty
  a_irq_up: assert property (p_irq_up) else $error("interrupt rose without cause");
  property p_irq_down; $fell(irq) |-> $past(pready) || $past(pready, 2); endproperty
  a_irq_down: assert property (p_irq_down) else $error("interrupt fell without access");
  // bus answer timing
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  property p_rdy_cause; pready |-> psel && penable && $past(penable); endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready outside access phase");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  cover property (bufClose);
  cover property (pslverr);
  cover property ($rose(irq));
endmodule
bind ucm_ctrl_char ucm_ctrl_char_asserts u_chk (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .rxChar(rxChar), .rxValid(rxValid), .bufData(bufData),
  .bufWrite(bufWrite), .bufClose(bufClose), .irq(irq));
`default_nettype wire

// *** sim/ucm_rx_source.sv ***
`timescale 1ns/1ps
`default_nettype none
module ucm_rx_source (
  input  wire logic       sys_clk,
  output logic      [7:0] rxChar,
  output logic            rxValid,
  output logic            bdIntEnable
);
  initial begin
    rxChar = 8'h00;
    rxValid = 1'b0;
    bdIntEnable = 1'b0;
  end
  // one character per pulse, data line scrambled after it
  task automatic send(input logic [7:0] ch, input logic ie);
    @(posedge sys_clk);
    rxValid <= 1'b1;
    rxChar <= ch;
    bdIntEnable <= ie;
    @(posedge sys_clk);
    rxValid <= 1'b0;
    rxChar <= ~ch;
  endtask
endmodule
`default_nettype wire

// *** verilog/ucm_ctrl_char.sv ***
`timescale 1ns/1ps
`default_nettype none
module ucm_ctrl_char (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ucm_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // character stream from the receiver
  input  wire logic [ucm_pkg::CHAR_W-1:0]  rxChar,
  input  wire logic                        rxValid,
  input  wire logic                        bdIntEnable,
  // towards the receive buffer
  output logic      [ucm_pkg::CHAR_W-1:0]  bufData,
  output logic                             bufWrite,
  output logic                             bufClose,
  output logic                             irq
);
  typedef struct packed {
    logic [ucm_pkg::NUM_ENTRIES-1:0][15:0] table_;
    logic [15:0]                           mask;
    logic [ucm_pkg::CHAR_W-1:0]            received_ctrl_char_reg;
    logic [ucm_pkg::EVT_W-1:0]             intMask;
    logic                                  enable;
    logic [ucm_pkg::IDX_W-1:0]             lastIdx;
    logic [31:0]                           prdata;
    logic                                  pready;
    logic                                  pslverr;
    logic [ucm_pkg::CHAR_W-1:0]            bufData;
    logic                                  bufWrite;
    logic                                  bufClose;
    logic [ucm_pkg::EVT_W-1:0]             evt;
    logic [ucm_pkg::EVT_W-1:0]             pendEvt;
  } ucm_top_state_t;

  ucm_top_state_t                st;
  ucm_top_state_t                next_st;
  logic [ucm_pkg::EVT_W-1:0]     status;
  logic                          irqOut;
  logic                          access;
  logic                          done;
  logic                          statusRead;
  logic [ucm_pkg::EVT_W-1:0]     irqEvt;

  ucm_match_if m ();

  // register address decode, shared by read and write paths
  function automatic logic addr_mapped(input logic [ucm_pkg::ADDR_W-1:0] a);
    addr_mapped = (a[ucm_pkg::WORD_SHIFT-1:0] == 2'h0) &&
                  ((a <= ucm_pkg::OFF_TABLE_LAST) || (a == ucm_pkg::OFF_MASK) ||
                   (a == ucm_pkg::OFF_RECEIVED_CTRL_CHAR_REG) || (a == ucm_pkg::OFF_STATUS) ||
                   (a == ucm_pkg::OFF_INTMASK) || (a == ucm_pkg::OFF_CTRL));
  endfunction

  function automatic logic [ucm_pkg::IDX_W-1:0] entry_idx(input logic [ucm_pkg::ADDR_W-1:0] a);
    entry_idx = a[ucm_pkg::WORD_SHIFT +: ucm_pkg::IDX_W];
  endfunction

  // comparison unit sees the live table and the incoming character
  assign m.table_ = st.table_;
  assign m.mask   = st.mask;
  assign m.ch     = rxChar;

  ucm_table_match u_match (
    .m (m)
  );

  // apb phases: pready rises one cycle into the access phase
  assign access     = psel && penable;
  assign done       = access && st.pready;
  assign statusRead = done && !pwrite && (paddr == ucm_pkg::OFF_STATUS);

  // events sampled too late for the read data are set again at the clear
  assign irqEvt     = st.evt | st.pendEvt;

  ucm_irq u_irq (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .evt     (irqEvt),
    .rdClr   (statusRead),
    .intMask (st.intMask),
    .status  (status),
    .irq     (irqOut)
  );

  // next state: bus slave and character handling
  always_comb begin
    next_st          = st;
    next_st.bufWrite = 1'b0;
    next_st.bufClose = 1'b0;
    next_st.evt      = ucm_pkg::EVT_RESET;
    next_st.pendEvt  = ucm_pkg::EVT_RESET;
    next_st.pready   = 1'b0;
    next_st.pslverr  = 1'b0;

    // answer after one wait cycle, read data captured with pready
    if (access && !st.pready) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !addr_mapped(paddr);
      next_st.prdata  = ucm_pkg::DATA_ZERO;
      // an event landing while status is sampled must survive the clear
      if (!pwrite && (paddr == ucm_pkg::OFF_STATUS))
        next_st.pendEvt = st.evt;
      if (!pwrite && addr_mapped(paddr)) begin
        if (paddr <= ucm_pkg::OFF_TABLE_LAST)
          next_st.prdata = {16'h0000, st.table_[entry_idx(paddr)]};
        else if (paddr == ucm_pkg::OFF_MASK)
          next_st.prdata = {16'h0000, st.mask};
        else if (paddr == ucm_pkg::OFF_RECEIVED_CTRL_CHAR_REG)
          next_st.prdata = {24'h000000, st.received_ctrl_char_reg};
        else if (paddr == ucm_pkg::OFF_STATUS)
          next_st.prdata = {27'h0000000, st.lastIdx, status};
        else if (paddr == ucm_pkg::OFF_INTMASK)
          next_st.prdata = {30'h00000000, st.intMask};
        else
          next_st.prdata = {31'h00000000, st.enable};
      end
    end

    // writes land only on the completing edge
    if (done && pwrite && addr_mapped(paddr)) begin
      if (paddr <= ucm_pkg::OFF_TABLE_LAST)
        next_st.table_[entry_idx(paddr)] = pwdata[15:0];
      else if (paddr == ucm_pkg::OFF_MASK)
        next_st.mask = pwdata[15:0];
      else if (paddr == ucm_pkg::OFF_INTMASK)
        next_st.intMask = pwdata[ucm_pkg::EVT_W-1:0];
      else if (paddr == ucm_pkg::OFF_CTRL)
        next_st.enable = pwdata[ucm_pkg::CTRL_ENABLE];
    end

    // character handling; recognition off passes all as data
    if (rxValid) begin
      if (st.enable && m.hit) begin
        next_st.lastIdx = m.hitIdx;
        if (m.reject) begin
          next_st.received_ctrl_char_reg                = rxChar;
          next_st.evt[ucm_pkg::EVT_REJECT] = 1'b1;
        end else begin
          next_st.bufData  = rxChar;
          next_st.bufWrite = 1'b1;
          next_st.bufClose = 1'b1;
          next_st.evt[ucm_pkg::EVT_CLOSE] = bdIntEnable;
        end
      end else begin
        next_st.bufData  = rxChar;
        next_st.bufWrite = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st          <= '0;
      st.table_   <= {ucm_pkg::NUM_ENTRIES{ucm_pkg::ENTRY_RESET}};
      st.mask     <= ucm_pkg::MASK_RESET;
      st.received_ctrl_char_reg     <= ucm_pkg::CHAR_RESET;
      st.intMask  <= ucm_pkg::EVT_RESET;
      st.bufData  <= ucm_pkg::CHAR_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata   = st.prdata;
  assign pready   = st.pready;
  assign pslverr  = st.pslverr;
  assign bufData  = st.bufData;
  assign bufWrite = st.bufWrite;
  assign bufClose = st.bufClose;
  assign irq      = irqOut;
endmodule
`default_nettype wire

// *** verilog/ucm_irq.sv ***
`timescale 1ns/1ps
`default_nettype none
module ucm_irq (
  input  wire logic                      sys_clk,
  input  wire logic                      rstn,
  input  wire logic [ucm_pkg::EVT_W-1:0] evt,
  input  wire logic                      rdClr,
  input  wire logic [ucm_pkg::EVT_W-1:0] intMask,
  output logic      [ucm_pkg::EVT_W-1:0] status,
  output logic                           irq
);
  typedef struct packed {
    logic [ucm_pkg::EVT_W-1:0] status;
    logic                      irq;
  } ucm_irq_state_t;

  ucm_irq_state_t st;
  ucm_irq_state_t next_st;

  // sticky bits, a new event beats the read clear
  always_comb begin
    next_st        = st;
    next_st.status = (rdClr ? ucm_pkg::EVT_RESET : st.status) | evt;
    next_st.irq    = |(next_st.status & intMask);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign status = st.status;
  assign irq    = st.irq;
endmodule
`default_nettype wire

// *** verilog/ucm_match_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ucm_match_if;
  logic [ucm_pkg::NUM_ENTRIES-1:0][15:0] table_;
  logic [15:0]                           mask;
  logic [7:0]                            ch;
  logic                                  hit;
  logic                                  reject;
  logic [ucm_pkg::IDX_W-1:0]             hitIdx;
  modport ctl (output table_, mask, ch, input hit, reject, hitIdx);
  modport cmp (input table_, mask, ch, output hit, reject, hitIdx);
endinterface
`default_nettype wire

// *** verilog/ucm_pkg.sv ***
package ucm_pkg;
  // character and table geometry
  localparam int          CHAR_W       = 8;
  localparam int          NUM_ENTRIES  = 8;
  localparam int          ENTRY_W      = 16;
  localparam int          IDX_W        = 3;
  localparam int          END_BIT      = 15;
  localparam int          REJECT_BIT   = 14;
  localparam int          MASK_TOP_HI  = 15;
  localparam int          MASK_TOP_LO  = 14;
  // apb register map, byte addresses
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFF_TABLE    = 8'h00;
  localparam logic [7:0]  OFF_TABLE_LAST = 8'h1c;
  localparam logic [7:0]  OFF_MASK     = 8'h20;
  localparam logic [7:0]  OFF_RECEIVED_CTRL_CHAR_REG     = 8'h24;
  localparam logic [7:0]  OFF_STATUS   = 8'h28;
  localparam logic [7:0]  OFF_INTMASK  = 8'h2c;
  localparam logic [7:0]  OFF_CTRL     = 8'h30;
  localparam int          WORD_SHIFT   = 2;
  // interrupt status layout
  localparam int          EVT_W        = 2;
  localparam int          EVT_CLOSE    = 0;
  localparam int          EVT_REJECT   = 1;
  // control register layout
  localparam int          CTRL_ENABLE  = 0;
  // reset values
  localparam logic [15:0] ENTRY_RESET  = 16'h8000;
  localparam logic [15:0] MASK_RESET   = 16'hc0ff;
  localparam logic [7:0]  CHAR_RESET   = 8'h00;
  localparam logic [1:0]  EVT_RESET    = 2'h0;
  localparam logic [31:0] DATA_ZERO    = 32'h0000_0000;

  // masked comparison of one entry against a received character
  function automatic logic ucm_char_match(input logic [15:0] entry,
                                          input logic [15:0] mask,
                                          input logic [7:0]  ch);
    ucm_char_match = (((entry[CHAR_W-1:0] ^ ch) & mask[CHAR_W-1:0]) == 8'h00);
  endfunction
endpackage

// *** verilog/ucm_table_match.sv ***
`timescale 1ns/1ps
`default_nettype none
module ucm_table_match (
  ucm_match_if.cmp m
);
  // scan from the first entry, stop at the end marker, first hit wins
  always_comb begin
    logic stop;
    stop     = 1'b0;
    m.hit    = 1'b0;
    m.reject = 1'b0;
    m.hitIdx = '0;
    for (int i = 0; i < ucm_pkg::NUM_ENTRIES; i++) begin
      if (m.table_[i][ucm_pkg::END_BIT])
        stop = 1'b1;
      if (!stop && !m.hit &&
          ucm_pkg::ucm_char_match(m.table_[i], m.mask, m.ch)) begin
        m.hit    = 1'b1;
        m.reject = m.table_[i][ucm_pkg::REJECT_BIT];
        m.hitIdx = ucm_pkg::IDX_W'(i);
      end
    end
  end
endmodule
`default_nettype wire
